// ### pkg/kpd_regs.svh
// Offsets, field positions, reset values and timing counts of the pulse dialler.
// Assumes the system clock mclk runs at 200 MHz.
`ifndef KPD_REGS_SVH
`define KPD_REGS_SVH

// ****************************************************************
// Clock and divider
// ****************************************************************
`define KPD_MCLK_HZ        200000000
`define KPD_DP_NORM_HZ     10
`define KPD_DP_TEST_HZ     932
`define KPD_CL_PER_DP      30
`define KPD_DIV_NORM       (`KPD_MCLK_HZ / (`KPD_DP_NORM_HZ * `KPD_CL_PER_DP))
`define KPD_DIV_TEST       (`KPD_MCLK_HZ / (`KPD_DP_TEST_HZ * `KPD_CL_PER_DP))

// ****************************************************************
// Timing in divided-clock periods
// ****************************************************************
`define KPD_RST_DELAY_TENTHS_DP 16
`define KPD_RST_DELAY_CL   ((`KPD_RST_DELAY_TENTHS_DP * `KPD_CL_PER_DP) / 10)
`define KPD_IDP_DP         8
`define KPD_IDP_CL         (`KPD_IDP_DP * `KPD_CL_PER_DP)
`define KPD_BRK_32_CL      ((3 * `KPD_CL_PER_DP) / 5)
`define KPD_BRK_21_CL      ((2 * `KPD_CL_PER_DP) / 3)
`define KPD_ENTRY_CL       4
`define KPD_RELEASE_CL     3
`define KPD_DEPTH          23

// ****************************************************************
// Keycodes
// ****************************************************************
`define KPD_CODE_ZERO      4'hA
`define KPD_CODE_STAR      4'hB
`define KPD_CODE_REDIAL    4'hC

// ****************************************************************
// Register map and fields
// ****************************************************************
`define KPD_ADR_CTRL       8'h00
`define KPD_ADR_STATUS     8'h04
`define KPD_CTRL_RATIO_BIT 0
`define KPD_CTRL_RESET     1'h0
`define KPD_ST_WR_LSB      0
`define KPD_ST_RD_LSB      8
`define KPD_ST_OVF_BIT     16
`define KPD_ST_REDIAL_BIT  17
`define KPD_ST_STBY_BIT    18
`define KPD_ST_MUTE_BIT    19

`endif

// ### pkg/kpd_pkg.sv
// Types shared by the pulse dialler.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package kpd_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_BREAK, ST_MAKE} kpd_state_e;
   typedef struct packed {
      logic       valid;
      logic [3:0] code;
   } kpd_key_s;
endpackage : kpd_pkg
`default_nettype wire

// ### hdl/kpd_dialler.sv
// Pulse dialler core: key scan, debounce, redial memory, pulse output, power-enable handling.
// Assumes all pins are synchronous to mclk and a classic Wishbone master on the register port.
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`include "kpd_regs.svh"
`default_nettype none

// Overview of operation
// - Divided clock rate is normal or test, chosen by rate_select_in.
// - Time base is mclk, whether from crystal or external clock.
// - Power-enable low in standby: state reset except write pointer and overflow flag, keys ignored, RAM kept.
// - Power-enable high: logic runs and keys are accepted.
// - Power-enable low beyond reset delay gives one reset pulse, then standby.
// - Shorter power-enable drops cause no reset and no disturbance.
// - One column high with one row low is a valid key, decoded to 4 bits.
// - Any other column and row combination is rejected.
// - Key accepted after three to four divided periods closed.
// - Next key refused until contact open two to three divided periods.
// - Keys sampled only on divided-clock ticks.
// - Accepted key stored at write pointer, then pointer increments.
// - Each fetched keycode increments read pointer; dial while pointers differ.
// - Memory holds 23 codes; storing into the last entry wraps the pointer and flags overflow.
// - Overflow disables redial until first key of next call clears pointer.
// - First key not redial clears write pointer, stores at zero, increments.
// - First key redial keeps pointer and replays stored codes.
// - Keys during redial replay are discarded.
// - After replay finishes, new keys are stored and dialled normally.
// - Hold stops dialling after current digit, or at once in a gap; keys still accepted.
// - Digit strobe high while pulsing a digit, low in every gap.
// - Mute output active during dialling, with an inverted twin.
// - Reset delay equals 1.6 dialling-pulse periods.
// - Stored key raises mute, waits one gap, then strobes and pulses.
// - After hold, no fetch until hold drops and a full gap passes.
module kpd_dialler #(
   parameter int DIV_NORM = `KPD_DIV_NORM,
   parameter int DIV_TEST = `KPD_DIV_TEST,
   parameter int DEPTH    = `KPD_DEPTH
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Control pins
   input  wire logic        power_enable_in,
   input  wire logic        rate_select_in,
   input  wire logic        hold_in,
   // Key matrix: columns active high, rows active low
   input  wire logic        column_in_1,
   input  wire logic        column_in_2,
   input  wire logic        column_in_3,
   input  wire logic        row_in_1,
   input  wire logic        row_in_2,
   input  wire logic        row_in_3,
   input  wire logic        row_in_4,
   // Line side
   output logic             line_pulse_out,
   output logic             mute_out,
   output logic             mute_n_out,
   output logic             digit_strobe_out,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int DW = $clog2(DIV_NORM > DIV_TEST ? DIV_NORM : DIV_TEST);
   generate
      if (DIV_NORM < 2 || DIV_TEST < 2 || DEPTH < 2 || DEPTH > 31) begin : g_bad
         $error("kpd_dialler: unsupported divider or depth");
      end
   endgenerate
   // ****************************************************************
   // Key decode
   // ****************************************************************
   function automatic kpd_pkg::kpd_key_s decode_key(input logic [2:0] col, input logic [3:0] row_n);
      kpd_pkg::kpd_key_s k;
      logic [3:0] row;
      k = '0;
      row = ~row_n;
      if ($onehot(col) && $onehot(row)) begin
         k.valid = 1'b1;
         if (row[3]) begin
            k.code = col[0] ? `KPD_CODE_STAR : (col[1] ? `KPD_CODE_ZERO : `KPD_CODE_REDIAL);
         end else begin
            k.code = 4'(3 * (row[1] ? 1 : (row[2] ? 2 : 0)) + (col[1] ? 2 : (col[2] ? 3 : 1)));
         end
      end
      return k;
   endfunction : decode_key

   kpd_pkg::kpd_key_s key;
   assign key = decode_key({column_in_3, column_in_2, column_in_1},
                           {row_in_4, row_in_3, row_in_2, row_in_1});
   // ****************************************************************
   // Divider and power-enable supervision
   // ****************************************************************
   logic [DW-1:0] div_r;
   logic          cl_tick;
   logic [5:0]    ce_cnt_r;
   logic          rst_pulse_r;
   logic          standby_r;
   logic          int_rst;
   // The divider keeps running through short drops so that the reset delay can be timed.
   always_ff @(posedge mclk) begin
      if (rst) begin
         div_r <= '0;
      end else if (div_r >= DW'((rate_select_in ? DIV_TEST : DIV_NORM) - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end
   assign cl_tick = (div_r == '0);

   always_ff @(posedge mclk) begin
      if (rst) begin
         ce_cnt_r    <= '0;
         rst_pulse_r <= 1'b0;
         standby_r   <= 1'b1;
      end else begin
         rst_pulse_r <= 1'b0;
         if (power_enable_in) begin
            ce_cnt_r  <= '0;
            standby_r <= 1'b0;
         end else if (cl_tick && !standby_r) begin
            if (ce_cnt_r == 6'(`KPD_RST_DELAY_CL - 1)) begin
               rst_pulse_r <= 1'b1;
               standby_r   <= 1'b1;
            end else begin
               ce_cnt_r <= ce_cnt_r + 1'b1;
            end
         end
      end
   end
   assign int_rst = rst | rst_pulse_r | (standby_r & ~power_enable_in);

   // ****************************************************************
   // Debounce
   // ****************************************************************
   logic       armed_r;
   logic [2:0] db_cnt_r;
   logic [3:0] db_code_r;
   logic       accept_p;
   always_ff @(posedge mclk) begin
      if (int_rst) begin
         armed_r   <= 1'b1;
         db_cnt_r  <= '0;
         db_code_r <= '0;
         accept_p  <= 1'b0;
      end else begin
         accept_p <= 1'b0;
         if (cl_tick && power_enable_in) begin
            if (armed_r) begin
               if (!key.valid) begin
                  db_cnt_r <= '0;
               end else if (db_cnt_r != '0 && key.code == db_code_r) begin
                  if (db_cnt_r == 3'(`KPD_ENTRY_CL - 1)) begin
                     accept_p <= 1'b1;
                     armed_r  <= 1'b0;
                     db_cnt_r <= '0;
                  end else begin
                     db_cnt_r <= db_cnt_r + 1'b1;
                  end
               end else begin
                  db_code_r <= key.code;
                  db_cnt_r  <= 3'h1;
               end
            end else if (key.valid) begin
               db_cnt_r <= '0;
            end else if (db_cnt_r == 3'(`KPD_RELEASE_CL - 1)) begin
               armed_r  <= 1'b1;
               db_cnt_r <= '0;
            end else begin
               db_cnt_r <= db_cnt_r + 1'b1;
            end
         end
      end
   end

   // ****************************************************************
   // Redial memory and write pointer
   // ****************************************************************
   logic [3:0]    ram [DEPTH];
   logic [PW-1:0] write_pointer;
   logic [PW-1:0] read_pointer;
   logic          overflow_r;
   logic          first_key_r;
   logic          redial_r;
   logic          clear_rd_p;
   logic          redial_go_p;
   kpd_pkg::kpd_state_e state_r;
   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc
   // Write pointer and memory survive standby; only the global reset or a first key that is not redial, or is redial with overflow set, clears the pointer.
   always_ff @(posedge mclk) begin
      if (rst) begin
         write_pointer <= '0;
         overflow_r    <= 1'b0;
      end else if (accept_p) begin
         if (first_key_r && !(db_code_r == `KPD_CODE_REDIAL && !overflow_r)) begin
            ram[0]        <= db_code_r;
            write_pointer <= PW'(1);
            overflow_r    <= 1'b0;
         end else if (!first_key_r && !redial_r) begin
            ram[write_pointer] <= db_code_r;
            write_pointer      <= ptr_inc(write_pointer);
            if (write_pointer == PW'(DEPTH - 1)) begin
               overflow_r <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (int_rst) begin
         first_key_r <= 1'b1;
         redial_r    <= 1'b0;
         clear_rd_p  <= 1'b0;
         redial_go_p <= 1'b0;
      end else begin
         clear_rd_p  <= 1'b0;
         redial_go_p <= 1'b0;
         if (accept_p && first_key_r) begin
            first_key_r <= 1'b0;
            if (db_code_r == `KPD_CODE_REDIAL && !overflow_r) begin
               redial_r    <= 1'b1;
               redial_go_p <= 1'b1;
            end else begin
               clear_rd_p <= 1'b1;
            end
         end else if (redial_r && !redial_go_p && state_r == kpd_pkg::ST_IDLE
                      && read_pointer == write_pointer) begin
            redial_r <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Dialling sequencer
   // ****************************************************************
   logic       ratio_r;
   logic [7:0] gap_cnt_r;
   logic [4:0] ph_cnt_r;
   logic [3:0] pulses_r;
   always_ff @(posedge mclk) begin
      if (int_rst) begin
         state_r          <= kpd_pkg::ST_IDLE;
         read_pointer     <= '0;
         gap_cnt_r        <= '0;
         ph_cnt_r         <= '0;
         pulses_r         <= '0;
         mute_out         <= 1'b0;
         mute_n_out       <= 1'b1;
         digit_strobe_out <= 1'b0;
         line_pulse_out   <= 1'b0;
      end else if (clear_rd_p || redial_go_p) begin
         read_pointer <= '0;
      end else begin
         case (state_r)
            kpd_pkg::ST_IDLE: begin
               if (read_pointer != write_pointer && !first_key_r) begin
                  mute_out   <= 1'b1;
                  mute_n_out <= 1'b0;
                  gap_cnt_r  <= '0;
                  state_r    <= kpd_pkg::ST_GAP;
               end
            end
            kpd_pkg::ST_GAP: begin
               digit_strobe_out <= 1'b0;
               if (hold_in) begin
                  gap_cnt_r <= '0;
               end else if (cl_tick) begin
                  if (gap_cnt_r == 8'(`KPD_IDP_CL - 1)) begin
                     gap_cnt_r <= '0;
                     if (read_pointer == write_pointer) begin
                        mute_out   <= 1'b0;
                        mute_n_out <= 1'b1;
                        state_r    <= kpd_pkg::ST_IDLE;
                     end else begin
                        read_pointer <= ptr_inc(read_pointer);
                        if (ram[read_pointer] <= `KPD_CODE_ZERO && ram[read_pointer] != 4'h0) begin
                           pulses_r         <= ram[read_pointer];
                           digit_strobe_out <= 1'b1;
                           line_pulse_out   <= 1'b1;
                           ph_cnt_r         <= '0;
                           state_r          <= kpd_pkg::ST_BREAK;
                        end
                     end
                  end else begin
                     gap_cnt_r <= gap_cnt_r + 1'b1;
                  end
               end
            end
            kpd_pkg::ST_BREAK: begin
               if (cl_tick) begin
                  if (ph_cnt_r == 5'(ratio_r ? `KPD_BRK_21_CL - 1 : `KPD_BRK_32_CL - 1)) begin
                     ph_cnt_r       <= '0;
                     line_pulse_out <= 1'b0;
                     pulses_r       <= pulses_r - 1'b1;
                     state_r        <= kpd_pkg::ST_MAKE;
                  end else begin
                     ph_cnt_r <= ph_cnt_r + 1'b1;
                  end
               end
            end
            kpd_pkg::ST_MAKE: begin
               if (cl_tick) begin
                  if (ph_cnt_r == 5'(`KPD_CL_PER_DP - 1 - (ratio_r ? `KPD_BRK_21_CL : `KPD_BRK_32_CL))) begin
                     ph_cnt_r <= '0;
                     if (pulses_r == '0) begin
                        digit_strobe_out <= 1'b0;
                        state_r          <= kpd_pkg::ST_GAP;
                     end else begin
                        line_pulse_out <= 1'b1;
                        state_r        <= kpd_pkg::ST_BREAK;
                     end
                  end else begin
                     ph_cnt_r <= ph_cnt_r + 1'b1;
                  end
               end
            end
            default: state_r <= kpd_pkg::ST_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Wishbone slave: one control word, one status word
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         ratio_r  <= `KPD_CTRL_RESET;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= '0;
         if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == `KPD_ADR_CTRL && wb_sel_i[0]) begin
            ratio_r <= wb_dat_i[`KPD_CTRL_RATIO_BIT];
         end
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            if (!wb_we_i && wb_adr_i == `KPD_ADR_CTRL) begin
               wb_dat_o[`KPD_CTRL_RATIO_BIT] <= ratio_r;
            end else if (!wb_we_i && wb_adr_i == `KPD_ADR_STATUS) begin
               wb_dat_o[`KPD_ST_WR_LSB +: PW] <= write_pointer;
               wb_dat_o[`KPD_ST_RD_LSB +: PW] <= read_pointer;
               wb_dat_o[`KPD_ST_OVF_BIT]      <= overflow_r;
               wb_dat_o[`KPD_ST_REDIAL_BIT]   <= redial_r;
               wb_dat_o[`KPD_ST_STBY_BIT]     <= standby_r;
               wb_dat_o[`KPD_ST_MUTE_BIT]     <= mute_out;
            end
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   mute_inverse_a: assert property (mute_n_out == !mute_out)
      else $error("mute twin not inverse");
   strobe_gap_low_a: assert property (state_r == kpd_pkg::ST_GAP && $past(state_r) == kpd_pkg::ST_GAP
                                      |-> !digit_strobe_out)
      else $error("strobe high in gap");
   pulse_in_digit_a: assert property (line_pulse_out |-> digit_strobe_out && mute_out)
      else $error("line pulse outside digit");
   wrptr_range_a: assert property (int'(write_pointer) < DEPTH)
      else $error("write pointer out of range");
   store_advance_a: assert property (accept_p && !first_key_r && !redial_r
                                     |=> write_pointer == ptr_inc($past(write_pointer)))
      else $error("write pointer did not advance");
   redial_discard_a: assert property (accept_p && redial_r && !first_key_r
                                      |=> $stable(write_pointer))
      else $error("key stored during redial");
   hold_no_fetch_a: assert property (!int_rst && hold_in && state_r == kpd_pkg::ST_GAP
                                     |=> state_r != kpd_pkg::ST_BREAK && $stable(read_pointer))
      else $error("digit fetched during hold");
   reset_delay_a: assert property (rst_pulse_r |-> $past(ce_cnt_r) == 6'(`KPD_RST_DELAY_CL - 1)
                                   && standby_r && $past(cl_tick))
      else $error("reset pulse at wrong count");
   accept_valid_a: assert property (accept_p |-> $past(key.valid) && $past(cl_tick))
      else $error("invalid key accepted");
   idle_unmute_a: assert property (state_r == kpd_pkg::ST_IDLE && read_pointer == write_pointer
                                   && !clear_rd_p && !redial_go_p |=> !mute_out)
      else $error("mute held with nothing to dial");

   redial_run_c: cover property (redial_go_p ##1 redial_r [*8]);
   overflow_c: cover property ($rose(overflow_r));
   hold_gap_c: cover property (hold_in && state_r == kpd_pkg::ST_GAP);
   digit_done_c: cover property (state_r == kpd_pkg::ST_MAKE ##1 state_r == kpd_pkg::ST_GAP);

endmodule : kpd_dialler
`default_nettype wire

// ### verification/kpd_line_model.sv
// Key matrix and line-side model for the pulse dialler bench.
// Assumes the bench pulses clr before each digit train it measures.
`default_nettype none
module kpd_line_model (
   // Clock
   input  wire logic       mclk,
   // Bench control
   input  wire logic       clr,
   input  wire logic [2:0] col_sel,
   input  wire logic [3:0] row_sel,
   // Device pins
   input  wire logic       line,
   output logic [2:0]      cols,
   output logic [3:0]      rows,
   // Measurements
   output int              pulses,
   output int              brk_len
);
   timeunit 1ns;
   timeprecision 1ps;
   int run;
   // Open contacts fall to the pull levels, so columns rest low and rows rest high.
   assign cols = col_sel;
   assign rows = ~row_sel;
   always_ff @(posedge mclk) begin
      run <= line ? run + 1 : 0;
      if (clr) pulses <= 0;
      else if (line && run == 0) pulses <= pulses + 1;
      if (!line && run != 0) brk_len <= run;
   end
endmodule : kpd_line_model
`default_nettype wire

// ### verification/test_keypad_pulse_dialler.sv
// Self-checking bench for the pulse dialler: key entry, line pulses, redial, hold, power drops.
// Assumes the shortened dividers 4 and 3 and the register map of kpd_regs.svh.
`include "kpd_regs.svh"
`default_nettype none
module test_keypad_pulse_dialler;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 0, rst = 1, pwr = 0, rsel = 0, hold = 0, clr = 1;
   logic        cyc = 0, stb = 0, we = 0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0, rk = 4'h0;
   logic [2:0]  ck = 3'h0, cols;
   logic [3:0]  rows;
   logic [31:0] wdat = 32'h0, rdat, s;
   logic        line, mute, mute_n, strobe, ack;
   int          pulses, brk_len, mismatches = 0, comparisons = 0, cyc_n = 0, tk = 4;

   initial forever #2.5 mclk = ~mclk;

   kpd_line_model i_far (.mclk(mclk), .clr(clr), .col_sel(ck), .row_sel(rk), .line(line),
      .cols(cols), .rows(rows), .pulses(pulses), .brk_len(brk_len));
   kpd_dialler #(.DIV_NORM(4), .DIV_TEST(3), .DEPTH(23)) i_dut (.mclk(mclk), .rst(rst),
      .power_enable_in(pwr), .rate_select_in(rsel), .hold_in(hold),
      .column_in_1(cols[0]), .column_in_2(cols[1]), .column_in_3(cols[2]),
      .row_in_1(rows[0]), .row_in_2(rows[1]), .row_in_3(rows[2]), .row_in_4(rows[3]),
      .line_pulse_out(line), .mute_out(mute), .mute_n_out(mute_n), .digit_strobe_out(strobe),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task conclude;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task check_bit(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask : check_bit
   task check_val(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", n, e, g);
      end
   endtask : check_val
   // Ack is read as sampled at the edge, before that edge's updates land.
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      do @(posedge mclk); while (ack !== 1'b1);
      s = rdat;
      cyc <= 0; stb <= 0; we <= 0;
   endtask : wb
   task status(input logic [4:0] wp, input logic [4:0] rp, input logic sb);
      wb(`KPD_ADR_STATUS, 0, 32'h0);
      check_val("write_pointer", wp, s[`KPD_ST_WR_LSB +: 5]);
      check_val("read_pointer", rp, s[`KPD_ST_RD_LSB +: 5]);
      check_bit("standby", sb, s[`KPD_ST_STBY_BIT]);
   endtask : status
   task key(input logic [2:0] c, input logic [3:0] r, input int held);
      @(posedge mclk);
      ck <= c; rk <= r;
      repeat (held * tk) @(posedge mclk);
      ck <= 3'h0; rk <= 4'h0;
      repeat (8 * tk) @(posedge mclk);
   endtask : key
   task wait_mute(input logic lvl);
      while (mute !== lvl) begin
         @(posedge mclk);
         if (line === 1'b1) check_bit("digit_strobe_out", 1'b1, strobe);
      end
      check_bit("mute_n_out", ~lvl, mute_n);
   endtask : wait_mute
   task dial_start;
      wait_mute(1'b1);
      clr <= 1;
      @(posedge mclk);
      clr <= 0;
   endtask : dial_start
   task dial_end(input int np, input int brk);
      wait_mute(1'b0);
      check_val("pulses", np, pulses);
      check_val("break_length", brk, brk_len);
   endtask : dial_end

   always @(posedge mclk) begin
      cyc_n++;
      if (cyc_n == 60000) begin
         mismatches++;
         conclude;
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 0;
      @(posedge mclk);
      check_bit("mute_out", 1'b0, mute);
      check_bit("line_pulse_out", 1'b0, line);
      status(5'h0, 5'h0, 1'b1);
      wb(8'h10, 0, 32'h0);
      check_val("unmapped", 32'h0, s);
      pwr <= 1;
      key(3'h2, 4'h1, 8);
      dial_start;
      dial_end(2, 18 * 4);
      status(5'h1, 5'h1, 1'b0);
      rsel <= 1;
      tk = 3;
      wb(`KPD_ADR_CTRL, 1, 32'h1);
      key(3'h2, 4'h8, 8);
      dial_start;
      dial_end(10, 20 * 3);
      key(3'h3, 4'h1, 10);
      key(3'h2, 4'h3, 10);
      key(3'h1, 4'h1, 2);
      status(5'h2, 5'h2, 1'b0);
      hold <= 1;
      key(3'h1, 4'h1, 8);
      dial_start;
      repeat (300 * tk) @(posedge mclk);
      check_val("pulses_held", 0, pulses);
      status(5'h3, 5'h2, 1'b0);
      hold <= 0;
      dial_end(1, 20 * 3);
      pwr <= 0;
      repeat (20 * tk) @(posedge mclk);
      pwr <= 1;
      status(5'h3, 5'h3, 1'b0);
      pwr <= 0;
      repeat (60 * tk) @(posedge mclk);
      status(5'h3, 5'h0, 1'b1);
      pwr <= 1;
      repeat (2 * tk) @(posedge mclk);
      check_bit("mute_out", 1'b0, mute);
      key(3'h4, 4'h8, 8);
      dial_start;
      key(3'h2, 4'h2, 8);
      dial_end(13, 20 * 3);
      status(5'h3, 5'h3, 1'b0);
      key(3'h1, 4'h1, 8);
      dial_start;
      dial_end(1, 20 * 3);
      status(5'h4, 5'h4, 1'b0);
      hold <= 1;
      repeat (23) key(3'h1, 4'h1, 5);
      status(5'h4, 5'h4, 1'b0);
      check_bit("overflow", 1'b1, s[`KPD_ST_OVF_BIT]);
      pwr <= 0;
      repeat (60 * tk) @(posedge mclk);
      hold <= 0;
      pwr <= 1;
      key(3'h4, 4'h8, 8);
      dial_start;
      wait_mute(1'b0);
      check_val("pulses", 0, pulses);
      status(5'h1, 5'h1, 1'b0);
      check_bit("overflow", 1'b0, s[`KPD_ST_OVF_BIT]);
      conclude;
   end
endmodule : test_keypad_pulse_dialler
`default_nettype wire
